// file: hw/thm_defs.vh
`ifndef THM_DEFS_VH
`define THM_DEFS_VH

// Operating modes
`define THM_MODE_ACTIVE 2'b00
`define THM_MODE_MONITOR 2'b01
`define THM_MODE_HIBERNATE 2'b10

// Frame rates in frames per second, and the clock rate in Hz
`define THM_ACTIVE_FPS 100
`define THM_MONITOR_FPS 25
`define THM_CLK_HZ 250000000

// Post-reset init time in ms, and its cycle count
`define THM_INIT_MS 200
`define THM_INIT_CYCLES (`THM_CLK_HZ / 1000 * `THM_INIT_MS)

// Watchdog timeout in ms
`define THM_WDOG_MS 50
`define THM_WDOG_CYCLES (`THM_CLK_HZ / 1000 * `THM_WDOG_MS)

// Target address default (arbitrary) and register pointer layout
`define THM_TARGET_ADDR 7'h38
`define THM_REG_RATE_ACTIVE 8'h00
`define THM_REG_RATE_MONITOR 8'h01
`define THM_REG_MODE 8'h02
`define THM_REG_FE_CFG 8'h03
`define THM_REG_STATUS 8'h04

`endif

// file: hw/thm_sync.v
`timescale 1ns/1ps
module thm_sync (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Asynchronous level in, synchronised level out
    input wire asyncIn,
    output reg syncOut
);
    reg stage1;

    always @(posedge sys_clk)
    begin
        if (reset)
        begin
            stage1 <= 1'b1;
            syncOut <= 1'b1;
        end
        else
        begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule // thm_sync

// file: hw/thm_frame_timer.v
`timescale 1ns/1ps
`include "thm_defs.vh"
module thm_frame_timer (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Control
    input wire run,
    input wire [31:0] period,
    // One-cycle frame strobe
    output reg tick
);
    reg [31:0] count;

    always @(posedge sys_clk)
    begin
        if (reset || !run)
        begin
            count <= 32'h0000_0000;
            tick <= 1'b0;
        end
        else if (count + 32'h0000_0001 >= period)
        begin
            count <= 32'h0000_0000;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 32'h0000_0001;
            tick <= 1'b0;
        end
    end
endmodule // thm_frame_timer

// file: hw/thm_mode_ctrl.v
// Behaviour
// [R1] Active mode scans at 100 frames/s by default; host rate register changes it.
// [R2] Monitor mode scans at 25 frames/s by default; host may change it.
// [R3] Monitor runs only a presence check, no full processing.
// [R4] Presence detected in monitor returns immediately to active scanning.
// [R5] Serial port closed during monitor; host must not transfer then.
// [R6] Hibernate powers down and reacts only to host reset.
// [R7] Host reset wakes from hibernate; after any reset mode is active.
// [R8] Low level on host_reset_n is a reset request.
// [R9] Interrupt output tells host that new touch data is ready.
// [R10] I2C port is a target only, never drives clock.
// [R11] Transfer starts with 7-bit address then direction bit, 1 read.
// [R12] STOP ends packet; repeated START ends current and begins next.
// [R13] Front-end configuration is written over the serial interface.
// [R14] Watchdog recovers the chip if processing stops.
// [R15] Interrupt only after initialisation completes, then reporting begins.
// [R16] Host expects reports no sooner than 200 ms after reset.
// [R17] No address acknowledge while monitoring or hibernating.
`timescale 1ns/1ps
`include "thm_defs.vh"
module thm_mode_ctrl #(
    parameter [31:0] INIT_CYCLES = `THM_INIT_CYCLES,
    parameter [31:0] WDOG_CYCLES = `THM_WDOG_CYCLES,
    // Frame periods derive from this; short runs may lower it
    parameter [31:0] CLK_HZ = `THM_CLK_HZ
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Host pins
    input wire host_reset_n,
    input wire sclIn,
    input wire sdaIn,
    output reg sdaOe_n,
    output reg touchInt_n,
    // Processing side
    input wire touchPresent,
    input wire touchDataReady,
    input wire procHeartbeat,
    input wire [7:0] touchByte,
    // Outputs to the rest of the chip
    output reg [1:0] mode,
    output reg scanStrobe,
    output reg presenceOnly,
    output reg powerDown,
    output reg [7:0] panel_front_end,
    output reg panelFrontEndWr
);
    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_ACK = 3'd2;
    localparam [2:0] ST_WDATA = 3'd3;
    localparam [2:0] ST_RDATA = 3'd4;
    localparam [2:0] ST_RACK = 3'd5;
    localparam [7:0] ACTIVE_FPS_DEF = `THM_ACTIVE_FPS;
    localparam [7:0] MONITOR_FPS_DEF = `THM_MONITOR_FPS;

    wire hostRstN;
    wire scl;
    wire sda;
    reg sclD;
    reg sdaD;
    reg [2:0] busState;
    reg [3:0] bitCnt;
    reg [7:0] shiftReg;
    reg readDir;
    reg havePtr;
    reg ackAddr;
    reg [7:0] regPtr;
    reg [7:0] activeRate;
    reg [7:0] monitorRate;
    reg initDone;
    reg [31:0] initCnt;
    reg [31:0] wdogCnt;
    reg hbD;
    reg softReset;
    wire frameTick;
    reg [31:0] framePeriod;

    thm_sync uRst (.sys_clk(sys_clk), .reset(reset), .asyncIn(host_reset_n),
        .syncOut(hostRstN));
    thm_sync uScl (.sys_clk(sys_clk), .reset(reset), .asyncIn(sclIn), .syncOut(scl));
    thm_sync uSda (.sys_clk(sys_clk), .reset(reset), .asyncIn(sdaIn), .syncOut(sda));

    // Low host reset, power-on reset or watchdog all restart the block
    wire anyReset = reset || !hostRstN || softReset; // [R8] [R7] [R6]

    function [31:0] rateToPeriod;
        input [7:0] fps;
        begin
            if (fps == 8'h00)
                rateToPeriod = CLK_HZ;
            else
                rateToPeriod = CLK_HZ / fps;
        end
    endfunction

    always @*
    begin
        if (mode == `THM_MODE_MONITOR)
            framePeriod = rateToPeriod(monitorRate); // [R2]
        else
            framePeriod = rateToPeriod(activeRate); // [R1]
    end

    thm_frame_timer uFrame (
        .sys_clk(sys_clk),
        .reset(anyReset),
        .run(initDone && mode != `THM_MODE_HIBERNATE),
        .period(framePeriod),
        .tick(frameTick)
    );

    wire startCond = sclD && scl && sdaD && !sda;
    wire stopCond = sclD && scl && !sdaD && sda;
    wire sclRise = !sclD && scl;
    wire sclFall = sclD && !scl;
    wire portOpen = (mode == `THM_MODE_ACTIVE); // [R5] [R17]

    // Mode, init and watchdog
    always @(posedge sys_clk)
    begin
        if (anyReset)
        begin
            mode <= `THM_MODE_ACTIVE; // [R7]
            initDone <= 1'b0;
            initCnt <= 32'h0000_0000;
            wdogCnt <= 32'h0000_0000;
            hbD <= 1'b0;
            softReset <= 1'b0;
            scanStrobe <= 1'b0;
            presenceOnly <= 1'b0;
            powerDown <= 1'b0;
            touchInt_n <= 1'b1;
        end
        else
        begin
            hbD <= procHeartbeat;
            scanStrobe <= frameTick && initDone;
            presenceOnly <= (mode == `THM_MODE_MONITOR); // [R3]
            powerDown <= (mode == `THM_MODE_HIBERNATE); // [R6]
            if (!initDone)
            begin
                // Reports wait the full init time after reset
                if (initCnt + 32'h0000_0001 >= INIT_CYCLES)
                    initDone <= 1'b1; // [R15] [R16]
                initCnt <= initCnt + 32'h0000_0001;
            end
            if (mode == `THM_MODE_HIBERNATE)
                wdogCnt <= 32'h0000_0000;
            else if (hbD != procHeartbeat)
                wdogCnt <= 32'h0000_0000;
            else if (wdogCnt + 32'h0000_0001 >= WDOG_CYCLES)
                softReset <= 1'b1; // [R14]
            else
                wdogCnt <= wdogCnt + 32'h0000_0001;
            if (mode == `THM_MODE_MONITOR && touchPresent)
                mode <= `THM_MODE_ACTIVE; // [R4]
            else if (busState == ST_ACK && !readDir && havePtr && sclFall
                && regPtr == `THM_REG_MODE && shiftReg[1:0] != 2'b11)
                mode <= shiftReg[1:0];
            // Interrupt held low until host starts a read or mode leaves active
            if (initDone && mode == `THM_MODE_ACTIVE && touchDataReady)
                touchInt_n <= 1'b0; // [R9] [R15]
            else if (busState == ST_RDATA || mode != `THM_MODE_ACTIVE)
                touchInt_n <= 1'b1;
        end
    end

    // I2C target; only pulls SDA, never drives SCL
    always @(posedge sys_clk)
    begin
        if (anyReset)
        begin
            sclD <= 1'b1;
            sdaD <= 1'b1;
            busState <= ST_IDLE;
            bitCnt <= 4'h0;
            shiftReg <= 8'h00;
            readDir <= 1'b0;
            havePtr <= 1'b0;
            regPtr <= 8'h00;
            sdaOe_n <= 1'b1; // [R10]
            ackAddr <= 1'b0;
            activeRate <= ACTIVE_FPS_DEF;
            monitorRate <= MONITOR_FPS_DEF;
            panel_front_end <= 8'h00;
            panelFrontEndWr <= 1'b0;
        end
        else
        begin
            sclD <= scl;
            sdaD <= sda;
            panelFrontEndWr <= 1'b0;
            if (!portOpen)
            begin
                busState <= ST_IDLE;
                sdaOe_n <= 1'b1; // [R5] [R17]
            end
            else if (startCond)
            begin
                // Repeated START closes the packet and opens a new one
                busState <= ST_ADDR; // [R12]
                bitCnt <= 4'h0;
                havePtr <= 1'b0;
                sdaOe_n <= 1'b1;
            end
            else if (stopCond)
            begin
                busState <= ST_IDLE; // [R12]
                sdaOe_n <= 1'b1;
            end
            else
            begin
                case (busState)
                    ST_ADDR, ST_WDATA:
                    begin
                        if (sclRise)
                        begin
                            shiftReg <= {shiftReg[6:0], sda};
                            bitCnt <= bitCnt + 4'h1;
                        end
                        else if (sclFall && bitCnt == 4'h8)
                        begin
                            bitCnt <= 4'h0;
                            if (busState == ST_ADDR)
                            begin
                                if (shiftReg[7:1] == `THM_TARGET_ADDR) // [R11]
                                begin
                                    readDir <= shiftReg[0];
                                    ackAddr <= 1'b1;
                                    busState <= ST_ACK;
                                    sdaOe_n <= 1'b0;
                                end
                                else
                                    busState <= ST_IDLE;
                            end
                            else
                            begin
                                busState <= ST_ACK;
                                sdaOe_n <= 1'b0;
                            end
                        end
                    end
                    ST_ACK:
                    begin
                        if (sclFall)
                        begin
                            ackAddr <= 1'b0;
                            if (readDir)
                            begin
                                busState <= ST_RDATA;
                                shiftReg <= (regPtr == `THM_REG_STATUS) ?
                                    {5'h00, initDone, mode} : touchByte;
                                // Enable low pulls SDA, so it follows the bit
                                sdaOe_n <= (regPtr == `THM_REG_STATUS) ?
                                    1'b0 : touchByte[7];
                                bitCnt <= 4'h1;
                            end
                            else
                            begin
                                busState <= ST_WDATA;
                                sdaOe_n <= 1'b1;
                                // Address byte carries no pointer
                                if (ackAddr)
                                    havePtr <= 1'b0;
                                else if (!havePtr)
                                begin
                                    havePtr <= 1'b1;
                                    regPtr <= shiftReg;
                                end
                                else
                                begin
                                    case (regPtr)
                                        `THM_REG_RATE_ACTIVE: activeRate <= shiftReg; // [R1]
                                        `THM_REG_RATE_MONITOR: monitorRate <= shiftReg; // [R2]
                                        `THM_REG_FE_CFG:
                                        begin
                                            panel_front_end <= shiftReg; // [R13]
                                            panelFrontEndWr <= 1'b1;
                                        end
                                        default: ;
                                    endcase
                                end
                            end
                        end
                    end
                    ST_RDATA:
                    begin
                        if (sclFall)
                        begin
                            if (bitCnt == 4'h8)
                            begin
                                busState <= ST_RACK;
                                sdaOe_n <= 1'b1;
                            end
                            else
                            begin
                                sdaOe_n <= shiftReg[7 - bitCnt[2:0]];
                                bitCnt <= bitCnt + 4'h1;
                            end
                        end
                    end
                    ST_RACK:
                    begin
                        if (sclRise)
                            busState <= sda ? ST_IDLE : ST_ACK;
                    end
                    default: busState <= ST_IDLE;
                endcase
            end
        end
    end
endmodule // thm_mode_ctrl

// file: testbench/thm_mode_checker.sv
`timescale 1ns/1ps
module thm_mode_checker #(
    parameter [31:0] INIT_CYCLES = 32'h0000_0014
) (
    // Clock and reset
    input wire sys_clk,
    input wire reset,
    // Host pins
    input wire host_reset_n,
    input wire sdaOe_n,
    input wire touchInt_n,
    // Processing side
    input wire touchPresent,
    input wire touchDataReady,
    // Mode outputs
    input wire [1:0] mode,
    input wire presenceOnly,
    input wire powerDown,
    input wire panelFrontEndWr
);
    // Cleared by the pin itself: the device sees it later, so this is an upper bound
    reg [31:0] sinceRst;
    always @(posedge sys_clk)
    begin
        if (reset || !host_reset_n)
            sinceRst <= 32'h0000_0000;
        else
            sinceRst <= sinceRst + 32'h0000_0001;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    reset_state_a: assert property (disable iff (1'b0) reset |=> mode == 2'h0 && touchInt_n)
        else $error("state not cleared by reset");
    int_cause_a: assert property ($fell(touchInt_n) |->
        $past(touchDataReady) && sinceRst >= INIT_CYCLES)
        else $error("interrupt without data or before init");
    monitor_wake_a: assert property (mode == 2'h1 && touchPresent |=> mode == 2'h0)
        else $error("touch in monitor did not wake");
    presence_flag_a: assert property (!$changed(mode) |-> presenceOnly == (mode == 2'h1))
        else $error("presence flag disagrees with mode");
    power_flag_a: assert property (!$changed(mode) |-> powerDown == (mode == 2'h2))
        else $error("power-down flag disagrees with mode");
    quiet_bus_a: assert property (!sdaOe_n |-> $past(mode) == 2'h0)
        else $error("bus driven outside active mode");
    hib_hold_a: assert property (mode == 2'h2 && host_reset_n && $past(host_reset_n) &&
        $past(host_reset_n, 2) && $past(host_reset_n, 3) |=> mode == 2'h2)
        else $error("left hibernate without host reset");
    hostrst_wake_a: assert property (!host_reset_n [*4] |-> ##[1:4] mode == 2'h0)
        else $error("host reset ignored");
    cfg_write_a: assert property (panelFrontEndWr |-> mode == 2'h0 ##1 !panelFrontEndWr)
        else $error("config strobe malformed");
endmodule // thm_mode_checker

bind thm_mode_ctrl thm_mode_checker #(.INIT_CYCLES(INIT_CYCLES)) modeCheck (
    .sys_clk(sys_clk),
    .reset(reset),
    .host_reset_n(host_reset_n),
    .sdaOe_n(sdaOe_n),
    .touchInt_n(touchInt_n),
    .touchPresent(touchPresent),
    .touchDataReady(touchDataReady),
    .mode(mode),
    .presenceOnly(presenceOnly),
    .powerDown(powerDown),
    .panelFrontEndWr(panelFrontEndWr)
);

// file: testbench/thm_host_model.sv
`timescale 1ns/1ps
module thm_host_model (
    // Clock
    input wire sys_clk,
    // Bus pins
    input wire sdaOe_n,
    output wire sclIn,
    output wire sdaIn
);
    reg scl = 1'b1;
    reg sda = 1'b1;
    // Pull-ups on both lines; only the host makes SCL
    assign sclIn = scl;
    assign sdaIn = sda & sdaOe_n;
    task automatic w;
        repeat (8) @(posedge sys_clk);
        #1;
    endtask
    // Also serves as repeated start when SCL is low
    task automatic start;
        sda = 1'b1;
        w;
        scl = 1'b1;
        w;
        sda = 1'b0;
        w;
        scl = 1'b0;
        w;
    endtask
    task automatic stop;
        sda = 1'b0;
        w;
        scl = 1'b1;
        w;
        sda = 1'b1;
        w;
    endtask
    // MSB first, ninth bit released; d of all ones reads and then refuses
    task automatic xfer(input logic [7:0] d, output logic [7:0] q, output logic ack);
        logic b;
        for (int i = 7; i >= -1; i--)
        begin
            sda = (i < 0) ? 1'b1 : d[i];
            w;
            scl = 1'b1;
            w;
            b = sdaIn;
            w;
            scl = 1'b0;
            w;
            if (i >= 0)
                q[i] = b;
        end
        ack = !b;
    endtask
endmodule // thm_host_model

// file: testbench/touch_host_mode_control_tb_top.sv
`timescale 1ns/1ps
`include "thm_defs.vh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
    $display("BAD %0t got %h want %h", $time, a, b); end end
module touch_host_mode_control_tb_top;
    localparam [31:0] INIT = 32'h0000_0014;
    localparam [31:0] WDOG = 32'h0000_0032;
    // 100 frames/s becomes 40 cycles
    localparam [31:0] CLKHZ = 32'h0000_0FA0;
    localparam [6:0] ADDR = `THM_TARGET_ADDR;
    reg sys_clk = 1'b0;
    reg reset = 1'b1;
    reg host_reset_n = 1'b1;
    reg touchPresent = 1'b0;
    reg touchDataReady = 1'b0;
    reg procHeartbeat = 1'b0;
    reg beatOn = 1'b1;
    reg [7:0] touchByte = 8'h00;
    wire sclIn, sdaIn, sdaOe_n, touchInt_n, scanStrobe, presenceOnly, powerDown, panelFrontEndWr;
    wire [1:0] mode;
    wire [7:0] panel_front_end;
    int fails = 0;
    int tests_run = 0;
    logic [7:0] q;
    logic [7:0] d;
    logic ack;
    int n;

    thm_mode_ctrl #(.INIT_CYCLES(INIT), .WDOG_CYCLES(WDOG), .CLK_HZ(CLKHZ)) DUT (
        .sys_clk(sys_clk), .reset(reset), .host_reset_n(host_reset_n),
        .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe_n(sdaOe_n), .touchInt_n(touchInt_n),
        .touchPresent(touchPresent), .touchDataReady(touchDataReady),
        .procHeartbeat(procHeartbeat), .touchByte(touchByte), .mode(mode),
        .scanStrobe(scanStrobe), .presenceOnly(presenceOnly), .powerDown(powerDown),
        .panel_front_end(panel_front_end), .panelFrontEndWr(panelFrontEndWr)
    );
    thm_host_model host (.sys_clk(sys_clk), .sdaOe_n(sdaOe_n), .sclIn(sclIn), .sdaIn(sdaIn));

    initial
        forever #2 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
        if (beatOn)
            procHeartbeat <= #1 ~procHeartbeat;

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic pulseReady;
        touchDataReady = 1'b1;
        cyc(1);
        touchDataReady = 1'b0;
        cyc(1);
    endtask
    task automatic pkt(input [6:0] a, input [7:0] p, input [7:0] v, input stp, output ok);
        logic k;
        host.start;
        host.xfer({a, 1'b0}, q, ok);
        if (ok)
        begin
            host.xfer(p, q, k);
            host.xfer(v, q, k);
        end
        if (stp)
            host.stop;
        cyc(4);
    endtask
    task automatic rd(output ok);
        logic k;
        host.start;
        host.xfer({ADDR, 1'b1}, q, ok);
        host.xfer(8'hFF, q, k);
        host.stop;
        cyc(4);
    endtask
    // Frame spacing in cycles; a zero rate means one frame a second
    function automatic int expGap(input int fps);
        return (fps == 0) ? CLKHZ : CLKHZ / fps;
    endfunction
    // Cycles between two frame strobes, after syncing to one
    task automatic gap(output int g);
        g = 0;
        while (scanStrobe !== 1'b1)
            cyc(1);
        cyc(1);
        while (scanStrobe !== 1'b1 && g < 1000)
        begin
            g++;
            cyc(1);
        end
        g++;
    endtask
    task automatic summarize;
        $display("Checks %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        void'($urandom(32'h3c9d));
        cyc(4);
        reset = 1'b0;
        `CHK(mode, `THM_MODE_ACTIVE)
        pulseReady;
        `CHK(touchInt_n, 1'b1)
        cyc(INIT + 10);
        pulseReady;
        `CHK(touchInt_n, 1'b0)
        gap(n);
        `CHK(n, expGap(`THM_ACTIVE_FPS))
        d = 8'($urandom_range(250, 40));
        pkt(ADDR, `THM_REG_RATE_ACTIVE, d, 1'b1, ack);
        gap(n);
        `CHK(n, expGap(d))
        pkt(ADDR ^ 7'h01, `THM_REG_FE_CFG, 8'h00, 1'b1, ack);
        `CHK(ack, 1'b0)
        // Back-to-back packets joined by repeated starts, edge values first
        for (int i = 0; i < 4; i++)
        begin
            d = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            pkt(ADDR, `THM_REG_FE_CFG, d, i == 3, ack);
            `CHK(ack, 1'b1)
            `CHK(panel_front_end, d)
        end
        touchByte = 8'($urandom);
        rd(ack);
        `CHK(q, touchByte)
        `CHK(touchInt_n, 1'b1)
        pkt(ADDR, `THM_REG_MODE, {6'h00, `THM_MODE_MONITOR}, 1'b1, ack);
        `CHK(presenceOnly, 1'b1)
        gap(n);
        `CHK(n, expGap(`THM_MONITOR_FPS))
        pkt(ADDR, `THM_REG_MODE, 8'h00, 1'b1, ack);
        `CHK(ack, 1'b0)
        `CHK(mode, `THM_MODE_MONITOR)
        touchPresent = 1'b1;
        cyc(2);
        touchPresent = 1'b0;
        `CHK(mode, `THM_MODE_ACTIVE)
        pkt(ADDR, `THM_REG_MODE, {6'h00, `THM_MODE_MONITOR}, 1'b1, ack);
        beatOn = 1'b0;
        cyc(WDOG + 10);
        beatOn = 1'b1;
        `CHK(mode, `THM_MODE_ACTIVE)
        cyc(INIT + 4);
        pkt(ADDR, `THM_REG_MODE, {6'h00, `THM_MODE_HIBERNATE}, 1'b1, ack);
        `CHK(powerDown, 1'b1)
        touchPresent = 1'b1;
        pkt(ADDR, `THM_REG_MODE, 8'h00, 1'b1, ack);
        touchPresent = 1'b0;
        `CHK(ack, 1'b0)
        `CHK(mode, `THM_MODE_HIBERNATE)
        host_reset_n = 1'b0;
        cyc(4);
        host_reset_n = 1'b1;
        cyc(4);
        `CHK(mode, `THM_MODE_ACTIVE)
        `CHK(powerDown, 1'b0)
        summarize;
    end

    // Several times the expected run length
    initial
    begin
        #200000;
        fails++;
        summarize;
    end
endmodule // touch_host_mode_control_tb_top
